/* rtl/osc_watch.sv */
`timescale 1ns/100ps
module osc_watch (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic osc_in,
    output logic osc_tick,
    output logic osc_halted,
    output logic halt_pulse,
    output logic start_pulse
);
    import rtc_power_pkg::*;

    logic osc_prev_reg;
    logic halted_reg;
    logic [10:0] idle_cnt_reg;
    wire rise = osc_in & ~osc_prev_reg;
    wire timeout = (idle_cnt_reg == 11'(HALT_CYCLES - 1));

    // Oscillator counts as halted until its first edge after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_prev_reg <= 1'b0;
            halted_reg <= 1'b1;
            idle_cnt_reg <= 11'h000;
        end else begin
            osc_prev_reg <= osc_in;
            if (rise) begin
                idle_cnt_reg <= 11'h000;
            end else if (!timeout) begin
                idle_cnt_reg <= idle_cnt_reg + 11'h001;
            end
            if (rise) begin
                halted_reg <= 1'b0;
            end else if (timeout) begin
                halted_reg <= 1'b1;
            end
        end
    end

    assign osc_tick = rise;
    assign osc_halted = halted_reg;
    assign halt_pulse = timeout & ~halted_reg & ~rise;
    assign start_pulse = rise & halted_reg;
endmodule : osc_watch

/* rtl/rtc_power_monitor_flags.sv */
// Summary of operation
// - Reset from 0 V: power-on set, low-supply cleared
// - Power-on, low-supply active high; running active low
// - Power-on/low-supply clear on 0; running stores writes
// - Oscillator stop drives running flag low, sticky
// - Power-on flag holds listed control fields at zero
// - Low-supply flag is bit 6 at index Fh
// - Threshold select is bit 7, same register
// - Select 0 picks 2.1 V, 1 picks 1.35 V
// - Sample once per second in 7.8 ms window
// - Set low-supply flag stops sampling until cleared
// - One threshold both directions, no hysteresis
// - Supply rise: main closed, backup open, delayed release
// - Halted oscillator: wait counts from oscillation start
// - Supply fall: main open, backup closed, reset low
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
module rtc_power_monitor_flags #(
    parameter int SECOND_OSC = rtc_power_pkg::SECOND_OSC_CYCLES,
    parameter int WINDOW_CYCLES = rtc_power_pkg::SAMPLE_WINDOW_CYCLES,
    parameter int RELEASE_WAIT = rtc_power_pkg::RELEASE_WAIT_OSC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [rtc_power_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [rtc_power_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic osc_in,
    input wire logic backup_below_high,
    input wire logic backup_below_low,
    input wire logic main_above_release,
    input wire logic main_below_detect,
    input wire logic periodic_evt,
    input wire logic weekday_alarm_evt,
    input wire logic daily_alarm_evt,
    output logic host_reset_n,
    output logic main_supply_switch,
    output logic backup_supply_switch,
    output logic supply_sense_en,
    output logic irq
);
    import rtc_power_pkg::*;

    function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[7:2];
    endfunction : reg_index

    function automatic logic known_index(input logic [5:0] i);
        known_index = (i == ADJ_IDX) || (i == CTRL1_IDX) || (i == CTRL2_IDX) ||
            (i == INT_STATUS_IDX) || (i == INT_ENABLE_IDX) || (i == INT_CLEAR_IDX);
    endfunction : known_index

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, wdata_reg;
    logic [3:0] wstrb_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    wire do_write = ~awready_reg & ~wready_reg & ~bvalid_reg;
    wire [5:0] wr_idx = reg_index(awaddr_reg);
    wire wr_lane = do_write & wstrb_reg[0];
    wire [7:0] wd = wdata_reg[7:0];
    wire wr_ctrl2 = wr_lane & (wr_idx == CTRL2_IDX);
    wire wr_ctrl1 = wr_lane & (wr_idx == CTRL1_IDX);
    wire wr_adj = wr_lane & (wr_idx == ADJ_IDX);
    wire wr_int_en = wr_lane & (wr_idx == INT_ENABLE_IDX);
    wire wr_int_clr = wr_lane & (wr_idx == INT_CLEAR_IDX);
    wire rd_take = arvalid & arready_reg;
    wire [5:0] rd_idx = reg_index(araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (awvalid && awready_reg) begin
                awaddr_reg <= awaddr;
                awready_reg <= 1'b0;
            end
            if (wvalid && wready_reg) begin
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
                wready_reg <= 1'b0;
            end
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= known_index(wr_idx) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Oscillator watch and one-second timing
    // ----------------------------------------------------------------
    logic osc_tick, osc_halted, halt_pulse, osc_start;
    logic [14:0] sec_cnt_reg;
    logic [16:0] win_cnt_reg;
    logic window_reg;

    osc_watch u_osc_watch (
        .aclk(aclk),
        .aresetn(aresetn),
        .osc_in(osc_in),
        .osc_tick(osc_tick),
        .osc_halted(osc_halted),
        .halt_pulse(halt_pulse),
        .start_pulse(osc_start)
    );

    wire sec_start = osc_tick & (sec_cnt_reg == 15'(SECOND_OSC - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sec_cnt_reg <= 15'h0000;
            win_cnt_reg <= 17'h00000;
            window_reg <= 1'b0;
        end else begin
            if (sec_start) begin
                sec_cnt_reg <= 15'h0000;
            end else if (osc_tick) begin
                sec_cnt_reg <= sec_cnt_reg + 15'h0001;
            end
            if (sec_start) begin
                win_cnt_reg <= 17'(WINDOW_CYCLES);
            end else if (win_cnt_reg != 17'h00000) begin
                win_cnt_reg <= win_cnt_reg - 17'h00001;
            end
            window_reg <= sec_start | (win_cnt_reg > 17'h00001);
        end
    end

    // ----------------------------------------------------------------
    // power_status_control and the registers it clears
    // ----------------------------------------------------------------
    logic power_on_reg, low_flag_reg, run_flag_reg, thresh_sel_reg, scr1_reg;
    logic period_flag_reg, week_flag_reg, day_flag_reg;
    logic [7:0] ctrl1_reg, adj_reg;
    wire threshold_select = thresh_sel_reg;
    wire below_sel = threshold_select ? backup_below_low : backup_below_high;
    wire sample_en = window_reg & ~low_flag_reg;
    wire low_hit = sample_en & below_sel;
    wire power_on_next = power_on_reg & ~(wr_ctrl2 & ~wd[POWER_ON_BIT]);
    wire low_flag_next = ~power_on_reg &
        (low_hit | (low_flag_reg & ~(wr_ctrl2 & ~wd[LOW_FLAG_BIT])));
    wire run_flag_next = ~halt_pulse & (wr_ctrl2 ? wd[RUN_FLAG_BIT] : run_flag_reg);
    wire period_flag_next = ~power_on_reg &
        (periodic_evt | (period_flag_reg & ~(wr_ctrl2 & ~wd[PERIOD_FLAG_BIT])));
    wire week_flag_next = ~power_on_reg &
        (weekday_alarm_evt | (week_flag_reg & ~(wr_ctrl2 & ~wd[WEEK_FLAG_BIT])));
    wire day_flag_next = ~power_on_reg &
        (daily_alarm_evt | (day_flag_reg & ~(wr_ctrl2 & ~wd[DAY_FLAG_BIT])));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_on_reg <= POWER_ON_RST;
            low_flag_reg <= LOW_FLAG_RST;
            run_flag_reg <= RUN_FLAG_RST;
            thresh_sel_reg <= 1'b0;
            scr1_reg <= 1'b0;
            period_flag_reg <= 1'b0;
            week_flag_reg <= 1'b0;
            day_flag_reg <= 1'b0;
            ctrl1_reg <= CTRL1_RST;
            adj_reg <= ADJ_RST;
        end else begin
            power_on_reg <= power_on_next;
            low_flag_reg <= low_flag_next;
            run_flag_reg <= run_flag_next;
            period_flag_reg <= period_flag_next;
            week_flag_reg <= week_flag_next;
            day_flag_reg <= day_flag_next;
            if (power_on_reg) begin
                thresh_sel_reg <= 1'b0;
                scr1_reg <= 1'b0;
                ctrl1_reg <= CTRL1_RST;
                adj_reg <= ADJ_RST;
            end else begin
                thresh_sel_reg <= wr_ctrl2 ? wd[THRESH_SEL_BIT] : thresh_sel_reg;
                scr1_reg <= wr_ctrl2 ? wd[SCR1_BIT] : scr1_reg;
                ctrl1_reg <= wr_ctrl1 ? wd : ctrl1_reg;
                adj_reg <= wr_adj ? wd : adj_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // Main-supply monitor
    // ----------------------------------------------------------------
    sup_state_t sup_state;
    logic [15:0] wait_cnt_reg;
    logic host_reset_n_reg, main_sw_reg, backup_sw_reg, sense_en_reg;
    wire wait_done = osc_tick & (wait_cnt_reg == 16'(RELEASE_WAIT - 1));
    wire supply_fail = (sup_state != SUP_DOWN) & main_below_detect;
    wire released = (sup_state == SUP_WAIT) & ~main_below_detect & wait_done;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sup_state <= SUP_DOWN;
            wait_cnt_reg <= 16'h0000;
        end else begin
            case (sup_state)
                SUP_DOWN: begin
                    wait_cnt_reg <= 16'h0000;
                    if (main_above_release && !main_below_detect) begin
                        sup_state <= SUP_WAIT;
                    end
                end
                SUP_WAIT: begin
                    if (main_below_detect) begin
                        sup_state <= SUP_DOWN;
                    end else if (wait_done) begin
                        sup_state <= SUP_UP;
                    end else if (osc_halted && !osc_start) begin
                        wait_cnt_reg <= 16'h0000;
                    end else if (osc_tick) begin
                        wait_cnt_reg <= wait_cnt_reg + 16'h0001;
                    end
                end
                SUP_UP: begin
                    if (main_below_detect) begin
                        sup_state <= SUP_DOWN;
                    end
                end
                default: begin
                    sup_state <= SUP_DOWN;
                end
            endcase
        end
    end

    wire [1:0] st_next_code = main_below_detect ? SUP_DOWN :
        (sup_state == SUP_DOWN && main_above_release) ? SUP_WAIT :
        released ? SUP_UP : sup_state;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_reset_n_reg <= 1'b0;
            main_sw_reg <= 1'b0;
            backup_sw_reg <= 1'b1;
            sense_en_reg <= 1'b0;
        end else begin
            host_reset_n_reg <= (st_next_code == SUP_UP);
            main_sw_reg <= (st_next_code != SUP_DOWN);
            backup_sw_reg <= (st_next_code == SUP_DOWN);
            sense_en_reg <= window_reg & ~low_flag_next;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status, enable and clear
    // ----------------------------------------------------------------
    logic [INT_W-1:0] int_status_reg, int_enable_reg;
    logic irq_reg;
    wire [INT_W-1:0] int_evt = {released, supply_fail, low_hit & ~power_on_reg & ~low_flag_reg,
        halt_pulse};
    wire [INT_W-1:0] int_clr = wr_int_clr ? wd[INT_W-1:0] : 4'h0;
    wire [INT_W-1:0] int_status_next = (int_status_reg & ~int_clr) | int_evt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_status_reg <= INT_RST;
            int_enable_reg <= INT_RST;
            irq_reg <= 1'b0;
        end else begin
            int_status_reg <= int_status_next;
            int_enable_reg <= wr_int_en ? wd[INT_W-1:0] : int_enable_reg;
            irq_reg <= |(int_status_next & (wr_int_en ? wd[INT_W-1:0] : int_enable_reg));
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    wire [7:0] ctrl2_rd = {thresh_sel_reg, low_flag_reg, run_flag_reg, power_on_reg, scr1_reg,
        period_flag_reg, week_flag_reg, day_flag_reg};
    wire [7:0] rd_byte = (rd_idx == CTRL2_IDX) ? ctrl2_rd :
        (rd_idx == CTRL1_IDX) ? ctrl1_reg :
        (rd_idx == ADJ_IDX) ? adj_reg :
        (rd_idx == INT_STATUS_IDX) ? {4'h0, int_status_reg} :
        (rd_idx == INT_ENABLE_IDX) ? {4'h0, int_enable_reg} : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (rd_take) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h000000, rd_byte};
            rresp_reg <= known_index(rd_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && rready) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
        end
    end

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign host_reset_n = host_reset_n_reg;
    assign main_supply_switch = main_sw_reg;
    assign backup_supply_switch = backup_sw_reg;
    assign supply_sense_en = sense_en_reg;
    assign irq = irq_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_por_flag_values: assert property (@(posedge aclk) $rose(aresetn) |->
        (power_on_reg && !low_flag_reg)) else $error("power-on flags wrong after reset");
    a_power_on_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_ctrl2 && wd[POWER_ON_BIT] && power_on_reg) |=> power_on_reg)
        else $error("power-on flag cleared by a write of 1");
    a_power_on_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(power_on_reg) |-> (ctrl1_reg == 8'h00 && adj_reg == 8'h00 && !thresh_sel_reg &&
        !low_flag_reg && !period_flag_reg)) else $error("fields not held at zero");
    a_halt_records: assert property (@(posedge aclk) disable iff (!aresetn)
        halt_pulse |=> !run_flag_reg ##1 (!run_flag_reg || $past(wr_ctrl2)))
        else $error("oscillator halt not recorded");
    a_low_in_window: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(low_flag_reg) |-> $past(window_reg) && $past(below_sel))
        else $error("low-supply flag set outside sample window");
    a_low_stops_sample: assert property (@(posedge aclk) disable iff (!aresetn)
        (low_flag_reg && !wr_ctrl2) |=> !supply_sense_en)
        else $error("sampling while flag set");
    a_threshold_pick: assert property (@(posedge aclk) disable iff (!aresetn)
        (sample_en && !power_on_reg &&
        (thresh_sel_reg ? backup_below_low : backup_below_high))
        |=> low_flag_reg) else $error("low supply missed at selected threshold");
    a_fail_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        main_below_detect |=> (!host_reset_n && backup_supply_switch &&
        !main_supply_switch)) else $error("supply fall not handled");
    a_release_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(host_reset_n) |-> $past(sup_state) == SUP_WAIT &&
        $past(wait_cnt_reg) == 16'(RELEASE_WAIT - 1)) else $error("early release");
    a_halt_holds_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        (sup_state == SUP_WAIT && osc_halted && !osc_start && !main_below_detect)
        |=> wait_cnt_reg == 16'h0000) else $error("wait counted while halted");
endmodule : rtc_power_monitor_flags

/* rtl/rtc_power_pkg.sv */
package rtc_power_pkg;
    // ----------------------------------------------------------------
    // Bus and timing
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SAMPLE_WINDOW_NS = 7_800_000;
    localparam int SAMPLE_WINDOW_CYCLES = SAMPLE_WINDOW_NS / CLK_PERIOD_NS;
    localparam int SECOND_OSC_CYCLES = 32768;
    localparam int RELEASE_WAIT_OSC = 1024;
    localparam int HALT_TIMEOUT_NS = 100_000;
    localparam int HALT_CYCLES = HALT_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [5:0] ADJ_IDX = 6'h07;
    localparam logic [5:0] CTRL1_IDX = 6'h0E;
    localparam logic [5:0] CTRL2_IDX = 6'h0F;
    localparam logic [5:0] INT_STATUS_IDX = 6'h10;
    localparam logic [5:0] INT_ENABLE_IDX = 6'h11;
    localparam logic [5:0] INT_CLEAR_IDX = 6'h12;

    // ----------------------------------------------------------------
    // Fields of power_status_control
    // ----------------------------------------------------------------
    localparam int THRESH_SEL_BIT = 7;
    localparam int LOW_FLAG_BIT = 6;
    localparam int RUN_FLAG_BIT = 5;
    localparam int POWER_ON_BIT = 4;
    localparam int SCR1_BIT = 3;
    localparam int PERIOD_FLAG_BIT = 2;
    localparam int WEEK_FLAG_BIT = 1;
    localparam int DAY_FLAG_BIT = 0;

    // ----------------------------------------------------------------
    // Interrupt status bits and reset values
    // ----------------------------------------------------------------
    localparam int INT_W = 4;
    localparam int INT_HALT = 0;
    localparam int INT_LOW = 1;
    localparam int INT_FAIL = 2;
    localparam int INT_READY = 3;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] ADJ_RST = 8'h00;
    localparam logic POWER_ON_RST = 1'b1;
    localparam logic LOW_FLAG_RST = 1'b0;
    localparam logic RUN_FLAG_RST = 1'b0;
    localparam logic [INT_W-1:0] INT_RST = 4'h0;

    typedef enum logic [1:0] {
        SUP_DOWN = 2'b00,
        SUP_WAIT = 2'b01,
        SUP_UP = 2'b10
    } sup_state_t;
endpackage : rtc_power_pkg

/* tb/osc_model.sv */
`timescale 1ns/100ps
module osc_model (
    input wire logic aclk,
    input wire logic run,
    output logic osc_in
);
    logic half;
    // ----------------------------------------------------------------
    // Crystal: period of four clock cycles, output rests low when stopped
    // ----------------------------------------------------------------
    initial begin
        half = 1'b0;
        osc_in = 1'b0;
    end
    always @(posedge aclk) begin
        half <= ~half;
        if (!run) osc_in <= 1'b0;
        else if (half) osc_in <= ~osc_in;
    end
endmodule : osc_model

/* tb/rtc_power_monitor_flags_tb.sv */
`timescale 1ns/100ps
module rtc_power_monitor_flags_tb;
    import rtc_power_pkg::*;
    localparam int RW = 4;
    localparam logic [7:0] A_C1 = {CTRL1_IDX, 2'b00};
    localparam logic [7:0] A_C2 = {CTRL2_IDX, 2'b00};
    localparam logic [7:0] A_ST = {INT_STATUS_IDX, 2'b00};
    localparam logic [7:0] A_EN = {INT_ENABLE_IDX, 2'b00};
    localparam logic [7:0] A_CL = {INT_CLEAR_IDX, 2'b00};
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, run;
    logic arvalid, arready, rvalid, rready, osc_in, irq, supply_sense_en;
    logic backup_below_high, backup_below_low, main_above_release, main_below_detect;
    logic periodic_evt, weekday_alarm_evt, daily_alarm_evt;
    logic host_reset_n, main_supply_switch, backup_supply_switch;
    logic [7:0] awaddr, araddr, d, r8;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    int miscompares, total_checks, n;

    rtc_power_monitor_flags #(.SECOND_OSC(16), .WINDOW_CYCLES(5), .RELEASE_WAIT(RW))
        rtc_power_monitor_flags_i (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .rvalid, .rready, .rdata, .rresp, .osc_in, .backup_below_high, .backup_below_low,
        .main_above_release, .main_below_detect, .periodic_evt, .weekday_alarm_evt,
        .daily_alarm_evt, .host_reset_n, .main_supply_switch, .backup_supply_switch,
        .supply_sense_en, .irq);
    osc_model osc_model_i (.aclk, .run, .osc_in);

    always #50 aclk = ~aclk;

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic stop_test();
        if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic oops();
        miscompares++;
        stop_test();
    endtask : oops
    task automatic tick(input int c);
        repeat (c) @(posedge aclk);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s);
        int k;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, v};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 1'b0;
        if (k >= 50) oops();
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        r8 = rdata[7:0];
        resp = rresp;
        rready <= 1'b0;
        if (k >= 50) oops();
    endtask : rd
    task automatic sense(input int c);
        n = 0;
        repeat (c) begin
            @(posedge aclk);
            if (supply_sense_en === 1'b1) n++;
        end
    endtask : sense
    task automatic wait_rel();
        for (n = 0; n < 400 && host_reset_n !== 1'b1; n++) @(posedge aclk);
        if (n >= 400) oops();
    endtask : wait_rel
    function automatic logic [7:0] exp_c2(input logic [7:0] v);
        return v & 8'hA8;
    endfunction : exp_c2

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {aclk, awvalid, wvalid, bready, arvalid, rready, run, aresetn} = '0;
        {backup_below_high, backup_below_low, main_above_release, main_below_detect} = '0;
        {periodic_evt, weekday_alarm_evt, daily_alarm_evt} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        miscompares = 0;
        total_checks = 0;
        void'($urandom(32'h72492701));
        tick(2);
        aresetn <= 1'b1;
        run <= 1'b1;
        rd(A_C2);
        chk(r8, 8'h10);
        chk({host_reset_n, main_supply_switch, backup_supply_switch}, 8'h01);
        wr(A_C1, 8'hFF, 4'h1);
        rd(A_C1);
        chk(r8, 8'h00);
        wr(A_C2, 8'h20, 4'h1);
        rd(A_C2);
        chk(r8, 8'h20);
        wr(A_C1, 8'hFF, 4'h1);
        rd(A_C1);
        chk(r8, 8'hFF);
        repeat (4) begin
            d = 8'($urandom);
            wr(A_C2, d, 4'h1);
            rd(A_C2);
            chk(r8, exp_c2(d));
        end
        wr(A_CL, 8'h0F, 4'h1);
        wr(A_EN, 8'h02, 4'h1);
        wr(A_C2, 8'h80, 4'h1);
        backup_below_high <= 1'b1;
        sense(200);
        chk(8'(n > 0 && n <= 20), 8'h01);
        rd(A_C2);
        chk(r8, 8'h80);
        backup_below_low <= 1'b1;
        sense(200);
        rd(A_C2);
        chk(r8, 8'hC0);
        chk(8'(irq), 8'h01);
        backup_below_low <= 1'b0;
        backup_below_high <= 1'b0;
        sense(200);
        chk(8'(n), 8'h00);
        rd(A_C2);
        chk(r8, 8'hC0);
        wr(A_EN, 8'h00, 4'h1);
        tick(2);
        chk(8'(irq), 8'h00);
        wr(A_EN, 8'h02, 4'h1);
        tick(2);
        chk(8'(irq), 8'h01);
        wr(A_CL, 8'h02, 4'h1);
        tick(2);
        chk(8'(irq), 8'h00);
        wr(A_C2, 8'h40, 4'h1);
        rd(A_C2);
        chk(r8, 8'h40);
        wr(A_C2, 8'h00, 4'h1);
        rd(A_C2);
        chk(r8, 8'h00);
        backup_below_high <= 1'b1;
        sense(200);
        rd(A_C2);
        chk(r8, 8'h40);
        backup_below_high <= 1'b0;
        wr(A_C2, 8'h20, 4'h1);
        periodic_evt <= 1'b1;
        weekday_alarm_evt <= 1'b1;
        daily_alarm_evt <= 1'b1;
        tick(1);
        {periodic_evt, weekday_alarm_evt, daily_alarm_evt} <= 3'h0;
        rd(A_C2);
        chk(r8, 8'h27);
        wr(A_C2, 8'h27, 4'h1);
        rd(A_C2);
        chk(r8, 8'h27);
        wr(A_C2, 8'h20, 4'h1);
        rd(A_C2);
        chk(r8, 8'h20);
        main_above_release <= 1'b1;
        tick(2);
        chk({host_reset_n, main_supply_switch, backup_supply_switch}, 8'h02);
        wait_rel();
        chk(8'(n >= RW * 4 - 6 && n <= RW * 4 + 10), 8'h01);
        main_below_detect <= 1'b1;
        tick(2);
        chk({host_reset_n, main_supply_switch, backup_supply_switch}, 8'h01);
        main_below_detect <= 1'b0;
        main_above_release <= 1'b0;
        wr(A_CL, 8'h0F, 4'h1);
        run <= 1'b0;
        tick(1100);
        rd(A_C2);
        chk(r8, 8'h00);
        rd(A_ST);
        chk(r8 & 8'h01, 8'h01);
        main_above_release <= 1'b1;
        tick(100);
        chk(8'(host_reset_n), 8'h00);
        run <= 1'b1;
        wait_rel();
        chk(8'(n >= RW * 4 - 6 && n <= RW * 4 + 12), 8'h01);
        rd(8'h80);
        chk({resp, r8[5:0]}, {RESP_SLVERR, 6'h00});
        wr(8'h80, 8'h55, 4'h1);
        chk(8'(resp), 8'(RESP_SLVERR));
        wr(A_C1, 8'h00, 4'h0);
        chk(8'(resp), 8'(RESP_OKAY));
        rd(A_C1);
        chk(r8, 8'hFF);
        stop_test();
    end
endmodule : rtc_power_monitor_flags_tb
